// file: logic/cgc_pkg.sv
package cgc_pkg;
	localparam int CLK_HZ       = 10_000_000;
	// modulation rate sits in the middle of the allowed band
	localparam int SSC_MOD_HZ   = 31_000;
	localparam int SSC_HALF_CYC = CLK_HZ / (2 * SSC_MOD_HZ);
	localparam int M_W          = 11;
	localparam int N_W          = 7;
	localparam int M_SPLIT      = 3;
	localparam int BYTE_W       = 8;
	localparam int MLO_LSB      = BYTE_W - M_SPLIT;
	localparam int IDX_W        = 6;
	localparam int BYTE_OFS_W   = 2;
	localparam int MARGIN_BIT   = 4;
	localparam int REF_DIS_LSB  = 0;
	localparam int REF_DIS_W    = 2;
	localparam int MEM_DIS_LSB  = 4;
	localparam int MEM_DIS_W    = 4;
	localparam int SYS_B_W      = 3;
	localparam logic [5:0] IDX_N1    = 6'h00;
	localparam logic [5:0] IDX_N2    = 6'h01;
	localparam logic [5:0] IDX_MHI   = 6'h02;
	localparam logic [5:0] IDX_MLO   = 6'h03;
	localparam logic [5:0] IDX_DIS   = 6'h04;
	localparam logic [5:0] IDX_STAT  = 6'h05;
	localparam logic [5:0] IDX_NONE  = 6'h3F;
	localparam logic [10:0] DEF_M    = 11'h280;
	localparam logic [6:0] N_66      = 7'h1E;
	localparam logic [6:0] N_100     = 7'h14;
	localparam logic [6:0] N_125     = 7'h10;
	localparam logic [6:0] N_133     = 7'h0F;
	localparam logic [2:0] RTC_HALF_DIV8  = 3'h3;
	localparam logic [2:0] RTC_HALF_DIV16 = 3'h7;

	typedef enum logic {SSC_RISE, SSC_FALL} cgc_ssc_dir_type;

	function automatic logic [N_W-1:0] freq_to_n(input logic [1:0] code);
		case (code)
			2'h0: return N_66;
			2'h1: return N_100;
			2'h2: return N_125;
			default: return N_133;
		endcase
	endfunction

	function automatic logic [IDX_W-1:0] reg_index(input logic [31:0] addr);
		if (addr[31:IDX_W+BYTE_OFS_W] != '0)
			return IDX_NONE;
		return addr[IDX_W+BYTE_OFS_W-1:BYTE_OFS_W];
	endfunction
endpackage

// file: logic/cgc_clk_if.sv
`timescale 1ns/1ps
interface cgc_clk_if;
	logic                              mr;
	logic                              pll_select;
	logic                              reference_select;
	logic                              rtc_divider_select;
	logic [cgc_pkg::REF_DIS_W-1:0]     ref_dis;
	logic [cgc_pkg::MEM_DIS_W-1:0]     mem_dis;
	logic                              crystal_reference;
	logic                              ext_clk_p;
	logic                              ext_clk_n;
	logic                              pll_sys_clk;
	logic                              pll_mem_clk;
	logic [3:0]                        oe_pins;
	logic                              system_clock_out;
	logic                              system_clock_out_oe;
	logic [cgc_pkg::SYS_B_W-1:0]       system_clock_bank;
	logic [cgc_pkg::SYS_B_W-1:0]       system_clock_bank_oe;
	logic [cgc_pkg::MEM_DIS_W-1:0]     memory_clock_bank;
	logic [cgc_pkg::MEM_DIS_W-1:0]     memory_clock_bank_oe;
	logic                              rtc_clock_out;
	logic                              rtc_clock_out_oe;
	logic                              reference_copy_out;
	logic                              reference_copy_out_oe;

	modport ctrl (output mr, pll_select, reference_select, rtc_divider_select, ref_dis, mem_dis,
		crystal_reference, ext_clk_p, ext_clk_n, pll_sys_clk, pll_mem_clk, oe_pins,
		input system_clock_out, system_clock_out_oe, system_clock_bank, system_clock_bank_oe,
		memory_clock_bank, memory_clock_bank_oe, rtc_clock_out, rtc_clock_out_oe,
		reference_copy_out, reference_copy_out_oe);
	modport gen (input mr, pll_select, reference_select, rtc_divider_select, ref_dis, mem_dis,
		crystal_reference, ext_clk_p, ext_clk_n, pll_sys_clk, pll_mem_clk, oe_pins,
		output system_clock_out, system_clock_out_oe, system_clock_bank, system_clock_bank_oe,
		memory_clock_bank, memory_clock_bank_oe, rtc_clock_out, rtc_clock_out_oe,
		reference_copy_out, reference_copy_out_oe);
endinterface

// file: logic/cgc_out_stage.sv
`timescale 1ns/1ps
module cgc_out_stage (
	input wire logic ref_clk,
	input wire logic reset_n,
	cgc_clk_if.gen   cif
);
	typedef struct packed {
		logic                          ref_prev;
		logic [2:0]                    rtc_cnt;
		logic                          rtc;
		logic                          ref_copy;
		logic                          sys;
		logic [cgc_pkg::SYS_B_W-1:0]   sysb;
		logic [cgc_pkg::MEM_DIS_W-1:0] memb;
		logic                          sys_oe;
		logic [cgc_pkg::SYS_B_W-1:0]   sysb_oe;
		logic [cgc_pkg::MEM_DIS_W-1:0] memb_oe;
		logic                          rtc_oe;
		logic                          copy_oe;
	} cgc_out_state_type;

	cgc_out_state_type s_reg;
	cgc_out_state_type s_next;
	logic              ref_level;
	logic              sys_src;
	logic              mem_src;
	logic [2:0]        rtc_half;

	////////////////////////////////////////////////////////////////////////
	// differential input counts high only when the positive leg is high and the negative leg is low
	assign ref_level = cif.reference_select ? (cif.ext_clk_p & ~cif.ext_clk_n) : cif.crystal_reference;
	assign sys_src   = cif.pll_select ? cif.pll_sys_clk : ref_level;
	assign mem_src   = cif.pll_select ? cif.pll_mem_clk : ref_level;
	assign rtc_half  = cif.rtc_divider_select ? cgc_pkg::RTC_HALF_DIV16 : cgc_pkg::RTC_HALF_DIV8;

	always_comb begin
		s_next          = s_reg;
		s_next.ref_prev = ref_level;
		s_next.ref_copy = ref_level;
		if (ref_level && !s_reg.ref_prev) begin
			if (s_reg.rtc_cnt >= rtc_half) begin
				s_next.rtc_cnt = '0;
				s_next.rtc     = ~s_reg.rtc;
			end else begin
				s_next.rtc_cnt = s_reg.rtc_cnt + 3'h1;
			end
		end
		s_next.sys     = sys_src & ~cif.mr;
		s_next.sysb    = {cgc_pkg::SYS_B_W{sys_src & ~cif.mr}};
		s_next.memb    = {cgc_pkg::MEM_DIS_W{mem_src & ~cif.mr}};
		s_next.sys_oe  = cif.oe_pins[0];
		s_next.sysb_oe = {cgc_pkg::SYS_B_W{cif.oe_pins[1]}};
		// bus disable bits can only take away, never add, drive
		s_next.memb_oe = {cgc_pkg::MEM_DIS_W{cif.oe_pins[2]}} & ~cif.mem_dis;
		s_next.rtc_oe  = cif.oe_pins[3] & ~cif.ref_dis[0];
		s_next.copy_oe = cif.oe_pins[3] & ~cif.ref_dis[1];
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign cif.system_clock_out      = s_reg.sys;
	assign cif.system_clock_out_oe   = s_reg.sys_oe;
	assign cif.system_clock_bank     = s_reg.sysb;
	assign cif.system_clock_bank_oe  = s_reg.sysb_oe;
	assign cif.memory_clock_bank     = s_reg.memb;
	assign cif.memory_clock_bank_oe  = s_reg.memb_oe;
	assign cif.rtc_clock_out         = s_reg.rtc;
	assign cif.rtc_clock_out_oe      = s_reg.rtc_oe;
	assign cif.reference_copy_out    = s_reg.ref_copy;
	assign cif.reference_copy_out_oe = s_reg.copy_oe;

	////////////////////////////////////////////////////////////////////////
	property p_mr_low;
		@(posedge ref_clk) disable iff (!reset_n)
		cif.mr |=> !cif.system_clock_out && cif.system_clock_bank == '0 && cif.memory_clock_bank == '0;
	endproperty
	a_mr_low: assert property (p_mr_low) else $error("clock banks not low in master reset");

	property p_ref_copy;
		@(posedge ref_clk) disable iff (!reset_n)
		reset_n |=> cif.reference_copy_out == $past(ref_level);
	endproperty
	a_ref_copy: assert property (p_ref_copy) else $error("reference copy does not follow selection");

	property p_bank_off;
		@(posedge ref_clk) disable iff (!reset_n)
		!cif.oe_pins[2] |=> cif.memory_clock_bank_oe == '0;
	endproperty
	a_bank_off: assert property (p_bank_off) else $error("memory bank driven while pin disables it");
endmodule

// file: logic/cgc_top.sv
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module cgc_top #(
	parameter int   SSC_HALF_CYC         = cgc_pkg::SSC_HALF_CYC,
	parameter logic N_WRITE_UNDER_SPREAD = 1'b0
) (
	input  wire logic                         ref_clk,
	input  wire logic                         reset_n,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output wire logic                         hreadyout,
	output wire logic                         hresp,
	output wire logic [31:0]                  hrdata,
	input  wire logic [3:0]                   freq_select_strap,
	input  wire logic                         master_reset_in,
	input  wire logic                         pll_select,
	input  wire logic                         reference_select,
	input  wire logic                         rtc_divider_select,
	input  wire logic                         spread_spectrum_enable,
	input  wire logic                         crystal_reference,
	input  wire logic                         ext_clk_p,
	input  wire logic                         ext_clk_n,
	input  wire logic                         pll_sys_clk,
	input  wire logic                         pll_mem_clk,
	input  wire logic                         oe_sys_pin,
	input  wire logic                         oe_sys_bank_pin,
	input  wire logic                         oe_mem_bank_pin,
	input  wire logic                         oe_ref_pin,
	output wire logic                         system_clock_out,
	output wire logic                         system_clock_out_oe,
	output wire logic [cgc_pkg::SYS_B_W-1:0]  system_clock_bank,
	output wire logic [cgc_pkg::SYS_B_W-1:0]  system_clock_bank_oe,
	output wire logic [cgc_pkg::MEM_DIS_W-1:0] memory_clock_bank,
	output wire logic [cgc_pkg::MEM_DIS_W-1:0] memory_clock_bank_oe,
	output wire logic                         rtc_clock_out,
	output wire logic                         rtc_clock_out_oe,
	output wire logic                         reference_copy_out,
	output wire logic                         reference_copy_out_oe,
	output wire logic [cgc_pkg::M_W-1:0]      fb_divider_out,
	output wire logic [cgc_pkg::N_W-1:0]      sys_divider_out,
	output wire logic [cgc_pkg::N_W-1:0]      mem_divider_out,
	output wire logic                         margin_active,
	output wire logic                         spread_active,
	output wire logic [7:0]                   ssc_phase
);
	localparam logic [7:0] SSC_TOP = 8'(SSC_HALF_CYC);

	if (SSC_HALF_CYC < 2 || SSC_HALF_CYC > 255) begin : g_chk
		$error("SSC_HALF_CYC must lie in 2..255");
	end

	typedef struct packed {
		logic                            load_pend;
		logic                            mr_prev;
		logic                            wr_pend;
		logic [cgc_pkg::IDX_W-1:0]       wr_idx;
		logic [31:0]                     rdata;
		logic [cgc_pkg::M_W-1:0]         m;
		logic [cgc_pkg::N_W-1:0]         n1;
		logic [cgc_pkg::N_W-1:0]         n2;
		logic                            margin_en;
		logic [cgc_pkg::REF_DIS_W-1:0]   ref_dis;
		logic [cgc_pkg::MEM_DIS_W-1:0]   mem_dis;
		logic [cgc_pkg::M_W-1:0]         eff_m;
		logic [cgc_pkg::N_W-1:0]         eff_n1;
		logic [cgc_pkg::N_W-1:0]         eff_n2;
		logic                            eff_margin;
		logic                            ssc_on;
		logic [7:0]                      ssc_cnt;
		cgc_pkg::cgc_ssc_dir_type        ssc_dir;
	} cgc_top_state_type;

	cgc_top_state_type             s_reg;
	cgc_top_state_type             s_next;
	logic                          margin_on;
	logic                          m_ok;
	logic                          n_ok;
	logic                          addr_ok;
	logic [cgc_pkg::IDX_W-1:0]     idx;
	logic [cgc_pkg::N_W-1:0]       strap_n1;
	logic [cgc_pkg::N_W-1:0]       strap_n2;
	logic                          mr_release;
	logic [cgc_pkg::M_W-1:0]       m_cur;
	logic [cgc_pkg::N_W-1:0]       n1_cur;
	logic [cgc_pkg::N_W-1:0]       n2_cur;
	logic                          wr_m_try;

	////////////////////////////////////////////////////////////////////////
	// strap decode: upper pair system, lower pair memory
	assign strap_n1   = cgc_pkg::freq_to_n(freq_select_strap[3:2]);
	assign strap_n2   = cgc_pkg::freq_to_n(freq_select_strap[1:0]);
	assign margin_on  = s_reg.margin_en && !spread_spectrum_enable;
	assign m_ok       = margin_on && !master_reset_in;
	// feedback stays locked under spread; output dividers follow the parameter
	assign n_ok       = s_reg.margin_en && !master_reset_in
		&& (!spread_spectrum_enable || N_WRITE_UNDER_SPREAD);
	assign addr_ok    = hsel && htrans[1] && hready;
	assign idx        = cgc_pkg::reg_index(haddr);
	assign mr_release = s_reg.mr_prev && !master_reset_in;
	assign m_cur      = s_reg.m;
	assign n1_cur     = s_reg.n1;
	assign n2_cur     = s_reg.n2;
	assign wr_m_try   = s_reg.wr_pend && (s_reg.wr_idx == cgc_pkg::IDX_MHI || s_reg.wr_idx == cgc_pkg::IDX_MLO);

	always_comb begin
		s_next         = s_reg;
		s_next.mr_prev = master_reset_in;
		s_next.wr_pend = addr_ok && hwrite;
		if (addr_ok)
			s_next.wr_idx = idx;

		// write data phase; zero wait states
		if (s_reg.wr_pend) begin
			case (s_reg.wr_idx)
				cgc_pkg::IDX_N1: begin
					if (n_ok)
						s_next.n1 = hwdata[cgc_pkg::N_W-1:0];
				end
				cgc_pkg::IDX_N2: begin
					if (n_ok)
						s_next.n2 = hwdata[cgc_pkg::N_W-1:0];
				end
				cgc_pkg::IDX_MHI: begin
					if (m_ok)
						s_next.m[cgc_pkg::M_W-1:cgc_pkg::M_SPLIT] = hwdata[cgc_pkg::BYTE_W-1:0];
				end
				cgc_pkg::IDX_MLO: begin
					if (m_ok)
						s_next.m[cgc_pkg::M_SPLIT-1:0] = hwdata[cgc_pkg::BYTE_W-1:cgc_pkg::MLO_LSB];
					s_next.margin_en = hwdata[cgc_pkg::MARGIN_BIT];
					s_next.ref_dis   = hwdata[cgc_pkg::REF_DIS_LSB +: cgc_pkg::REF_DIS_W];
				end
				cgc_pkg::IDX_DIS: begin
					s_next.mem_dis = hwdata[cgc_pkg::MEM_DIS_LSB +: cgc_pkg::MEM_DIS_W];
				end
				default: begin
				end
			endcase
		end

		// strap defaults win over any write in the same cycle
		if (s_reg.load_pend || master_reset_in || mr_release) begin
			s_next.load_pend = 1'b0;
			s_next.m         = cgc_pkg::DEF_M;
			s_next.n1        = strap_n1;
			s_next.n2        = strap_n2;
			s_next.margin_en = 1'b0;
			s_next.ref_dis   = '0;
			s_next.mem_dis   = '0;
		end

		// read captured after writes so back-to-back access sees new data
		if (addr_ok && !hwrite) begin
			case (idx)
				cgc_pkg::IDX_N1:   s_next.rdata = 32'(s_next.n1);
				cgc_pkg::IDX_N2:   s_next.rdata = 32'(s_next.n2);
				cgc_pkg::IDX_MHI:  s_next.rdata = 32'(s_next.m[cgc_pkg::M_W-1:cgc_pkg::M_SPLIT]);
				cgc_pkg::IDX_MLO:  s_next.rdata = 32'({s_next.m[cgc_pkg::M_SPLIT-1:0], s_next.margin_en,
					2'h0, s_next.ref_dis});
				cgc_pkg::IDX_DIS:  s_next.rdata = 32'({s_next.mem_dis, 4'h0});
				cgc_pkg::IDX_STAT: s_next.rdata = 32'({s_reg.ssc_on, s_reg.eff_margin, s_reg.mr_prev,
					freq_select_strap});
				default:           s_next.rdata = '0;
			endcase
		end

		// divider values handed to the synthesizer
		s_next.eff_margin = margin_on;
		if (margin_on) begin
			s_next.eff_m  = s_reg.m;
			s_next.eff_n1 = s_reg.n1;
			s_next.eff_n2 = s_reg.n2;
		end else begin
			s_next.eff_m  = cgc_pkg::DEF_M;
			s_next.eff_n1 = strap_n1;
			s_next.eff_n2 = strap_n2;
		end

		// triangle profile; depth is applied by the analog loop
		s_next.ssc_on = spread_spectrum_enable;
		if (!spread_spectrum_enable) begin
			s_next.ssc_cnt = '0;
			s_next.ssc_dir = cgc_pkg::SSC_RISE;
		end else begin
			case (s_reg.ssc_dir)
				cgc_pkg::SSC_RISE: begin
					s_next.ssc_cnt = s_reg.ssc_cnt + 8'h01;
					if (s_reg.ssc_cnt + 8'h01 >= SSC_TOP)
						s_next.ssc_dir = cgc_pkg::SSC_FALL;
				end
				cgc_pkg::SSC_FALL: begin
					s_next.ssc_cnt = s_reg.ssc_cnt - 8'h01;
					if (s_reg.ssc_cnt <= 8'h01)
						s_next.ssc_dir = cgc_pkg::SSC_RISE;
				end
				default: begin
					s_next.ssc_cnt = '0;
					s_next.ssc_dir = cgc_pkg::SSC_RISE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg           <= '0;
			s_reg.load_pend <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	cgc_clk_if cif ();

	assign cif.mr                 = master_reset_in;
	assign cif.pll_select         = pll_select;
	assign cif.reference_select   = reference_select;
	assign cif.rtc_divider_select = rtc_divider_select;
	assign cif.ref_dis            = s_reg.ref_dis;
	assign cif.mem_dis            = s_reg.mem_dis;
	assign cif.crystal_reference  = crystal_reference;
	assign cif.ext_clk_p          = ext_clk_p;
	assign cif.ext_clk_n          = ext_clk_n;
	assign cif.pll_sys_clk        = pll_sys_clk;
	assign cif.pll_mem_clk        = pll_mem_clk;
	assign cif.oe_pins            = {oe_ref_pin, oe_mem_bank_pin, oe_sys_bank_pin, oe_sys_pin};

	cgc_out_stage u_out (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.cif     (cif)
	);

	assign system_clock_out      = cif.system_clock_out;
	assign system_clock_out_oe   = cif.system_clock_out_oe;
	assign system_clock_bank     = cif.system_clock_bank;
	assign system_clock_bank_oe  = cif.system_clock_bank_oe;
	assign memory_clock_bank     = cif.memory_clock_bank;
	assign memory_clock_bank_oe  = cif.memory_clock_bank_oe;
	assign rtc_clock_out         = cif.rtc_clock_out;
	assign rtc_clock_out_oe      = cif.rtc_clock_out_oe;
	assign reference_copy_out    = cif.reference_copy_out;
	assign reference_copy_out_oe = cif.reference_copy_out_oe;
	assign fb_divider_out        = s_reg.eff_m;
	assign sys_divider_out       = s_reg.eff_n1;
	assign mem_divider_out       = s_reg.eff_n2;
	assign margin_active         = s_reg.eff_margin;
	assign spread_active         = s_reg.ssc_on;
	assign ssc_phase             = s_reg.ssc_cnt;
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign hrdata                = s_reg.rdata;

	////////////////////////////////////////////////////////////////////////
	property p_strap_decode;
		@(posedge ref_clk) disable iff (!reset_n)
		reset_n && !margin_on |=> sys_divider_out == $past(strap_n1) && mem_divider_out == $past(strap_n2)
			&& fb_divider_out == cgc_pkg::DEF_M;
	endproperty
	a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong");

	property p_margin_regs;
		@(posedge ref_clk) disable iff (!reset_n)
		margin_on |=> fb_divider_out == $past(m_cur) && sys_divider_out == $past(n1_cur) && margin_active;
	endproperty
	a_margin_regs: assert property (p_margin_regs) else $error("margin dividers not taken from registers");

	property p_mr_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		master_reset_in |=> m_cur == cgc_pkg::DEF_M && n1_cur == $past(strap_n1) && !s_reg.margin_en;
	endproperty
	a_mr_hold: assert property (p_mr_hold) else $error("dividers not held in master reset");

	property p_release_load;
		@(posedge ref_clk) disable iff (!reset_n)
		$fell(master_reset_in) |=> n2_cur == $past(strap_n2) && m_cur == cgc_pkg::DEF_M;
	endproperty
	a_release_load: assert property (p_release_load) else $error("no reload at reset release");

	property p_no_margin_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_m_try && !s_reg.margin_en && !master_reset_in && !s_reg.mr_prev && !s_reg.load_pend)
			|=> m_cur == $past(m_cur);
	endproperty
	a_no_margin_write: assert property (p_no_margin_write) else $error("feedback written without margin");

	property p_ssc_block;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_m_try && spread_spectrum_enable && !master_reset_in && !s_reg.mr_prev && !s_reg.load_pend)
			|=> m_cur == $past(m_cur);
	endproperty
	a_ssc_block: assert property (p_ssc_block) else $error("feedback written under spread");

	property p_ssc_off;
		@(posedge ref_clk) disable iff (!reset_n)
		!spread_spectrum_enable |=> ssc_phase == 8'h00 && !spread_active;
	endproperty
	a_ssc_off: assert property (p_ssc_off) else $error("spread profile active while disabled");
endmodule

// file: sim/cgc_board_model.sv
`timescale 1ns/1ps
module cgc_board_model (
	input  wire logic ref_clk,
	output wire logic crystal_reference,
	output wire logic ext_clk_p,
	output wire logic ext_clk_n,
	output wire logic pll_sys_clk,
	output wire logic pll_mem_clk
);
	logic [2:0] cnt_reg = 3'h0;
	// free-running stand-ins, one pattern per source so a wrong mux shows
	always @(posedge ref_clk) begin
		cnt_reg <= cnt_reg + 3'h1;
	end
	assign crystal_reference = cnt_reg[0];
	assign ext_clk_p         = cnt_reg[1];
	assign ext_clk_n         = ~cnt_reg[1];
	assign pll_sys_clk       = cnt_reg[2];
	assign pll_mem_clk       = cnt_reg[1] ^ cnt_reg[0];
endmodule

// file: sim/cgc_top_tb_top.sv
`timescale 1ns/1ps
module cgc_top_tb_top;
	logic        ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        master_reset_in = 1'b0, pll_select = 1'b1, reference_select = 1'b0;
	logic        rtc_divider_select = 1'b0, spread_spectrum_enable = 1'b0;
	logic        oe_sys_pin = 1'b1, oe_sys_bank_pin = 1'b1, oe_mem_bank_pin = 1'b1, oe_ref_pin = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]  htrans = 2'h0;
	logic [3:0]  freq_select_strap = 4'h0;
	wire logic   hready, crystal_reference, ext_clk_p, ext_clk_n, pll_sys_clk, pll_mem_clk;
	wire logic   system_clock_out, rtc_clock_out, margin_active, spread_active;
	wire logic   system_clock_out_oe, rtc_clock_out_oe, reference_copy_out, reference_copy_out_oe, hresp;
	wire logic [31:0] hrdata;
	wire logic [2:0]  system_clock_bank, system_clock_bank_oe;
	wire logic [7:0]  ssc_phase;
	wire logic [3:0]  memory_clock_bank, memory_clock_bank_oe;
	wire logic [10:0] fb_divider_out;
	wire logic [6:0]  sys_divider_out, mem_divider_out;
	logic        s, r;
	int          errors = 0, n_tests = 0, i, k, n;
	logic [6:0]  n_tab [4] = '{7'h1E, 7'h14, 7'h10, 7'h0F};
	////////////////////////////////////////////////////////////////
	always #50 ref_clk = ~ref_clk;
	cgc_board_model board (.ref_clk, .crystal_reference, .ext_clk_p, .ext_clk_n, .pll_sys_clk, .pll_mem_clk);
	cgc_top #(.SSC_HALF_CYC(4)) DUT (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .freq_select_strap, .master_reset_in,
		.pll_select, .reference_select, .rtc_divider_select, .spread_spectrum_enable, .crystal_reference,
		.ext_clk_p, .ext_clk_n, .pll_sys_clk, .pll_mem_clk, .oe_sys_pin, .oe_sys_bank_pin,
		.oe_mem_bank_pin, .oe_ref_pin, .system_clock_out, .system_clock_out_oe, .system_clock_bank,
		.system_clock_bank_oe, .memory_clock_bank, .memory_clock_bank_oe, .rtc_clock_out,
		.rtc_clock_out_oe, .reference_copy_out, .reference_copy_out_oe, .fb_divider_out,
		.sys_divider_out, .mem_divider_out, .margin_active, .spread_active, .ssc_phase);
	////////////////////////////////////////////////////////////////
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task wait_rdy;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) begin
			errors++;
			summarize();
		end
	endtask
	// single word transfer; data phase read taken at the closing edge
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	// phase of the divided output is unknown, so time one full period
	task until_rtc(input logic v);
		i = 0;
		while (rtc_clock_out !== v) begin
			settle(1);
			n++;
			i++;
			if (i > 40) begin
				errors++;
				summarize();
			end
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		settle(2);
		check(fb_divider_out, 11'h280);
		for (k = 0; k < 4; k++) begin
			freq_select_strap <= {k[1:0], ~k[1:0]};
			settle(2);
			check(sys_divider_out, n_tab[k]);
			check(mem_divider_out, n_tab[3-k]);
		end
		xfer(1, 32'h0, 32'h33);
		settle(2);
		check(sys_divider_out, 7'h0F);
		xfer(1, 32'hC, 32'h10);
		settle(2);
		check(margin_active, 1'b1);
		xfer(1, 32'h0, 32'h22);
		xfer(0, 32'h0, 32'h0);
		check(rd, 32'h22);
		xfer(1, 32'h8, 32'h60);
		freq_select_strap <= 4'h5;
		settle(2);
		check(sys_divider_out, 7'h22);
		check(fb_divider_out, 11'h300);
		xfer(0, 32'h14, 32'h0);
		check(rd[3:0], 4'h5);
		xfer(0, 32'h100, 32'h0);
		check(rd, 32'h0);
		check(hresp, 1'b0);
		spread_spectrum_enable <= 1'b1;
		settle(2);
		check({spread_active, margin_active}, 2'h2);
		check(ssc_phase, 8'h02);
		xfer(1, 32'h0, 32'h11);
		xfer(1, 32'h8, 32'h55);
		xfer(0, 32'h0, 32'h0);
		check(rd, 32'h22);
		xfer(0, 32'h8, 32'h0);
		check(rd, 32'h60);
		spread_spectrum_enable <= 1'b0;
		master_reset_in <= 1'b1;
		settle(2);
		check({system_clock_out, system_clock_bank, memory_clock_bank}, 8'h0);
		xfer(1, 32'h0, 32'h11);
		xfer(0, 32'h0, 32'h0);
		check(rd, 32'h14);
		master_reset_in <= 1'b0;
		settle(3);
		check({margin_active, sys_divider_out, fb_divider_out}, {1'b0, 7'h14, 11'h280});
		for (k = 0; k < 3; k++) begin
			pll_select <= (k == 0);
			reference_select <= (k == 2);
			settle(2);
			repeat (3) begin
				s = (k == 0) ? pll_sys_clk : (k == 1) ? crystal_reference : ext_clk_p & ~ext_clk_n;
				r = (k == 2) ? ext_clk_p & ~ext_clk_n : crystal_reference;
				settle(1);
				check(system_clock_out, s);
				check(reference_copy_out, r);
			end
		end
		reference_select <= 1'b0;
		for (k = 0; k < 2; k++) begin
			rtc_divider_select <= k[0];
			settle(40);
			until_rtc(1'b0);
			until_rtc(1'b1);
			n = 0;
			until_rtc(1'b0);
			until_rtc(1'b1);
			check(n, 16 << k);
		end
		{oe_sys_pin, oe_sys_bank_pin, oe_mem_bank_pin, oe_ref_pin} <= 4'h0;
		settle(2);
		check(memory_clock_bank_oe, 4'h0);
		check({system_clock_out_oe, system_clock_bank_oe, rtc_clock_out_oe, reference_copy_out_oe}, 6'h00);
		{oe_sys_pin, oe_sys_bank_pin, oe_mem_bank_pin, oe_ref_pin} <= 4'hF;
		xfer(1, 32'h10, 32'h50);
		settle(2);
		check(memory_clock_bank_oe, 4'hA);
		check({system_clock_out_oe, system_clock_bank_oe, rtc_clock_out_oe, reference_copy_out_oe}, 6'h3F);
		summarize();
	end
endmodule
